// >>> rtl/rcim_enable_mask.sv
`timescale 1ns/1ps
`include "rcim_regs.svh"

module rcim_enable_mask
  import rcim_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic set_strobe,
  input wire logic clear_strobe,
  input wire rcim_enable_t bit_data,
  output rcim_enable_t enable
);

  // Each enable bit is set by a one in a set write and cleared by a one in a clear write.
  // Zeros leave the bit alone; a set wins should both ever arrive together.
  genvar i;
  generate
    for (i = 0; i < `RCIM_ENABLE_WIDTH; i++)
    begin : g_bit
      always_ff @(posedge core_clk or negedge rst_n)
      begin
        if (!rst_n)
        begin
          enable[i] <= 1'h0;
        end
        else if (set_strobe && bit_data[i])
        begin
          enable[i] <= 1'h1;
        end
        else if (clear_strobe && bit_data[i])
        begin
          enable[i] <= 1'h0;
        end
      end
    end
  endgenerate

endmodule

// >>> rtl/rcim_pkg.sv
`include "rcim_regs.svh"

package rcim_pkg;

  // One-hot register select produced by the address decoder.
  typedef enum logic [4:0]
  {
    RCIM_SEL_NONE = 5'h01,
    RCIM_SEL_UNMASKED = 5'h02,
    RCIM_SEL_MASKED = 5'h04,
    RCIM_SEL_SET = 5'h08,
    RCIM_SEL_CLEAR = 5'h10
  } rcim_reg_sel_t;

  typedef logic [`RCIM_ENABLE_WIDTH-1:0] rcim_enable_t;
  typedef logic [`RCIM_STATUS_WIDTH-1:0] rcim_status_t;
  typedef logic [`RCIM_CHANNELS-1:0] rcim_chan_t;

endpackage

// >>> rtl/rcim_regs.svh
`ifndef RCIM_REGS_SVH
`define RCIM_REGS_SVH

// Register byte offsets on the register port.
`define RCIM_OFS_UNMASKED 8'h00
`define RCIM_OFS_MASKED 8'h04
`define RCIM_OFS_ENABLE_SET 8'h08
`define RCIM_OFS_ENABLE_CLEAR 8'h0C

// Field positions shared by the status and enable registers.
`define RCIM_CHANNELS 8
`define RCIM_PACKET_LSB 0
`define RCIM_LOW_BUFFER_LSB 8
`define RCIM_PULSE_LSB 16
`define RCIM_ENABLE_WIDTH 24
`define RCIM_STATUS_WIDTH 16

// Reset values.
`define RCIM_ENABLE_RESET 24'h000000
`define RCIM_RDATA_RESET 32'h00000000

`endif

// >>> rtl/rcim_top.sv
// The address-and-strobe port and the register addresses are this design's own decisions.
`timescale 1ns/1ps
`include "rcim_regs.svh"

// Overview of operation
// - The masked status register shows the enabled packet-pending state of channels 0 to 7 in bits 0 to 7.
// - The masked status register shows the enabled threshold-pending state of channels 0 to 7 in bits 8 to 15.
// - The enable set register sets each enable bit written as one and reads back the current enables.
// - A one in bits 16 to 23 of the set register enables the pulse interrupt of channels 0 to 7.
// - A one in bits 8 to 15 of the set register enables the threshold interrupt of channels 0 to 7.
// - A one in bits 0 to 7 of the set register enables the packet interrupt of channels 0 to 7.
// - The enable clear register clears each enable bit written as one and reads back the current enables.
// - A one in bits 16 to 23 of the clear register disables the pulse interrupt of channels 0 to 7.
// - A one in bits 8 to 15 of the clear register disables the threshold interrupt of channels 0 to 7.
// - A one in bits 0 to 7 of the clear register disables the packet interrupt of channels 0 to 7.
// - Bits 24 to 31 of the enable registers and bits 16 to 31 of the masked status carry no function.
// - An unmasked status register with the same layout shows every packet and threshold event before masking.

module rcim_top
  import rcim_pkg::*;
(
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  input wire rcim_chan_t rx_packet_event,
  input wire rcim_chan_t rx_low_buffer_event,
  input wire rcim_chan_t rx_pulse_event,
  output rcim_chan_t rx_packet_irq,
  output rcim_chan_t rx_low_buffer_irq,
  output rcim_chan_t rx_pulse_irq
);

  logic rst_meta_n;
  logic rst_n;
  rcim_reg_sel_t wr_sel;
  rcim_reg_sel_t rd_sel;
  rcim_enable_t enable;
  rcim_status_t unmasked;
  rcim_status_t masked;
  logic [31:0] next_rdata;

  // Maps a byte address to the one-hot register select; unaligned or unknown addresses select nothing.
  function automatic rcim_reg_sel_t rcim_decode(input logic [7:0] addr);
    rcim_reg_sel_t sel;
    sel = RCIM_SEL_NONE;
    case (addr)
      `RCIM_OFS_UNMASKED: sel = RCIM_SEL_UNMASKED;
      `RCIM_OFS_MASKED: sel = RCIM_SEL_MASKED;
      `RCIM_OFS_ENABLE_SET: sel = RCIM_SEL_SET;
      `RCIM_OFS_ENABLE_CLEAR: sel = RCIM_SEL_CLEAR;
      default: sel = RCIM_SEL_NONE;
    endcase
    return sel;
  endfunction

  // Releases the asynchronous reset through two flops so all logic leaves reset on one edge.
  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      rst_meta_n <= 1'h0;
      rst_n <= 1'h0;
    end
    else
    begin
      rst_meta_n <= 1'h1;
      rst_n <= rst_meta_n;
    end
  end

  // Decoding is shared by the write path and the read path.
  assign wr_sel = reg_wr ? rcim_decode(reg_addr) : RCIM_SEL_NONE;
  assign rd_sel = reg_rd ? rcim_decode(reg_addr) : RCIM_SEL_NONE;

  // Holds the 24 enable bits; only the low 24 write bits reach it, so bits 24 to 31 do nothing.
  rcim_enable_mask u_enable_mask
  (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .set_strobe(wr_sel == RCIM_SEL_SET),
    .clear_strobe(wr_sel == RCIM_SEL_CLEAR),
    .bit_data(reg_wdata[`RCIM_ENABLE_WIDTH-1:0]),
    .enable(enable)
  );

  // Captures the level of each channel's packet and threshold source before any masking.
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      unmasked <= '0;
    end
    else
    begin
      unmasked <= {rx_low_buffer_event, rx_packet_event};
    end
  end

  // Masked view: each captured event ANDed with its own enable bit, channel 0 in the low bit.
  assign masked = unmasked & enable[`RCIM_STATUS_WIDTH-1:0];

  // Drives the per-channel interrupt lines from flops, one channel per loop pass.
  genvar ch;
  generate
    for (ch = 0; ch < `RCIM_CHANNELS; ch++)
    begin : g_chan
      always_ff @(posedge core_clk or negedge rst_n)
      begin
        if (!rst_n)
        begin
          rx_packet_irq[ch] <= 1'h0;
          rx_low_buffer_irq[ch] <= 1'h0;
          rx_pulse_irq[ch] <= 1'h0;
        end
        else
        begin
          rx_packet_irq[ch] <= masked[`RCIM_PACKET_LSB + ch];
          rx_low_buffer_irq[ch] <= masked[`RCIM_LOW_BUFFER_LSB + ch];
          rx_pulse_irq[ch] <= rx_pulse_event[ch] & enable[`RCIM_PULSE_LSB + ch];
        end
      end
    end
  endgenerate

  // Selects the read value; reserved bits and unmapped addresses read as zero.
  always_comb
  begin
    next_rdata = `RCIM_RDATA_RESET;
    case (rd_sel)
      RCIM_SEL_NONE: next_rdata = `RCIM_RDATA_RESET;
      RCIM_SEL_UNMASKED: next_rdata = {16'h0000, unmasked};
      RCIM_SEL_MASKED: next_rdata = {16'h0000, masked};
      RCIM_SEL_SET: next_rdata = {8'h00, enable};
      RCIM_SEL_CLEAR: next_rdata = {8'h00, enable};
      default: next_rdata = `RCIM_RDATA_RESET;
    endcase
  end

  // Read data stands for the single cycle after the read strobe and is zero otherwise.
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      reg_rdata <= `RCIM_RDATA_RESET;
    end
    else
    begin
      reg_rdata <= next_rdata;
    end
  end

  // Checks on the register and interrupt behaviour, all in the synchronised reset domain.
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_n);

  sequence s_read_masked;
    reg_rd && reg_addr == `RCIM_OFS_MASKED;
  endsequence

  sequence s_read_unmasked;
    reg_rd && reg_addr == `RCIM_OFS_UNMASKED;
  endsequence

  sequence s_write_set;
    reg_wr && reg_addr == `RCIM_OFS_ENABLE_SET;
  endsequence

  sequence s_write_clear;
    reg_wr && reg_addr == `RCIM_OFS_ENABLE_CLEAR;
  endsequence

  sequence s_read_enable;
    reg_rd && (reg_addr == `RCIM_OFS_ENABLE_SET || reg_addr == `RCIM_OFS_ENABLE_CLEAR);
  endsequence

  a_masked_packet_read:
  assert property (s_read_masked |=> reg_rdata[7:0] == ($past(unmasked[7:0]) & $past(enable[7:0])))
    else $error("masked packet bits differ from event and enable");

  a_masked_low_read:
  assert property (s_read_masked |=> reg_rdata[15:8] == ($past(unmasked[15:8]) & $past(enable[15:8])))
    else $error("masked threshold bits differ from event and enable");

  a_set_keeps_others:
  assert property (s_write_set |=> enable == ($past(enable) | $past(reg_wdata[23:0])))
    else $error("set write did not OR into the enables");

  a_set_pulse_bits:
  assert property (s_write_set ##1 s_read_enable |=> reg_rdata[23:16] == ($past(enable[23:16], 2)
                   | $past(reg_wdata[23:16], 2)))
    else $error("pulse enables not set or not readable");

  a_set_low_bits:
  assert property (s_write_set |=> (enable[15:8] & $past(reg_wdata[15:8])) == $past(reg_wdata[15:8]))
    else $error("threshold enable not set by write of one");

  a_set_packet_bits:
  assert property (s_write_set |=> (enable[7:0] & $past(reg_wdata[7:0])) == $past(reg_wdata[7:0]))
    else $error("packet enable not set by write of one");

  a_clear_keeps_others:
  assert property (s_write_clear |=> enable == ($past(enable) & ~$past(reg_wdata[23:0])))
    else $error("clear write did not remove only the written ones");

  a_clear_pulse_bits:
  assert property (s_write_clear |=> (enable[23:16] & $past(reg_wdata[23:16])) == 8'h00)
    else $error("pulse enable survived a clear");

  a_clear_low_bits:
  assert property (s_write_clear |=> (enable[15:8] & $past(reg_wdata[15:8])) == 8'h00)
    else $error("threshold enable survived a clear");

  a_clear_packet_bits:
  assert property (s_write_clear ##1 s_read_enable |=> (reg_rdata[7:0] & $past(reg_wdata[7:0], 2)) == 8'h00)
    else $error("packet enable survived a clear");

  a_reserved_reads_zero:
  assert property ((s_read_enable |=> reg_rdata[31:24] == 8'h00)
                   and (s_read_masked |=> reg_rdata[31:16] == 16'h0000))
    else $error("reserved bits read nonzero");

  a_unmasked_view:
  assert property (s_read_unmasked |=> reg_rdata == {16'h0000, $past(unmasked)})
    else $error("unmasked read differs from captured events");

  a_event_reaches_raw:
  assert property (##1 unmasked == $past({rx_low_buffer_event, rx_packet_event}))
    else $error("unmasked status lags the sources by more than one cycle");

  a_enable_holds:
  assert property (!(reg_wr && (reg_addr == `RCIM_OFS_ENABLE_SET || reg_addr == `RCIM_OFS_ENABLE_CLEAR))
                   |=> $stable(enable))
    else $error("enables changed without a mask write");

  a_irq_masking:
  assert property (##1 (rx_packet_irq == ($past(unmasked[7:0]) & $past(enable[7:0]))
                   && rx_low_buffer_irq == ($past(unmasked[15:8]) & $past(enable[15:8]))))
    else $error("interrupt line not equal to event AND enable");

  a_pulse_gating:
  assert property (##1 rx_pulse_irq == ($past(rx_pulse_event) & $past(enable[23:16])))
    else $error("pulse line not gated by its enable");

  a_idle_rdata_zero:
  assert property (!reg_rd |=> reg_rdata == 32'h00000000)
    else $error("read data present without a read");

  // Further checks on readback, zero writes and quiet interrupt lines.
  // A zero in a mask write must never move an enable, so a full zero word leaves all enables alone.
  sequence s_read_clear;
    reg_rd && reg_addr == `RCIM_OFS_ENABLE_CLEAR;
  endsequence

  sequence s_write_zero;
    reg_wr && (reg_addr == `RCIM_OFS_ENABLE_SET || reg_addr == `RCIM_OFS_ENABLE_CLEAR) && reg_wdata[23:0] == 24'h000000;
  endsequence

  // A read of the set register returns the enables as they stood at the read.
  a_set_readback:
  assert property (s_read_enable |=> reg_rdata[23:0] == $past(enable))
    else $error("enable readback differs from the enables");

  // A read of the clear register returns the same enables with the reserved byte zero.
  a_clear_readback:
  assert property (s_read_clear |=> reg_rdata == {8'h00, $past(enable)})
    else $error("clear register readback differs from the enables");

  // Every one written to the pulse field of the set register turns its enable on.
  a_set_pulse_enable:
  assert property (s_write_set |=> (enable[23:16] & $past(reg_wdata[23:16])) == $past(reg_wdata[23:16]))
    else $error("pulse enable not set by write of one");

  // A threshold enable set by a write is seen by the read that follows.
  a_set_low_read:
  assert property (s_write_set ##1 s_read_enable |=> (reg_rdata[15:8] & $past(reg_wdata[15:8], 2))
                   == $past(reg_wdata[15:8], 2))
    else $error("threshold enable not readable after set");

  // A packet enable set by a write is seen by the read that follows.
  a_set_packet_read:
  assert property (s_write_set ##1 s_read_enable |=> (reg_rdata[7:0] & $past(reg_wdata[7:0], 2))
                   == $past(reg_wdata[7:0], 2))
    else $error("packet enable not readable after set");

  // A pulse enable cleared by a write reads back as zero.
  a_clear_pulse_read:
  assert property (s_write_clear ##1 s_read_enable |=> (reg_rdata[23:16] & $past(reg_wdata[23:16], 2)) == 8'h00)
    else $error("pulse enable readable after clear");

  // A threshold enable cleared by a write reads back as zero.
  a_clear_low_read:
  assert property (s_write_clear ##1 s_read_enable |=> (reg_rdata[15:8] & $past(reg_wdata[15:8], 2)) == 8'h00)
    else $error("threshold enable readable after clear");

  // A mask write of all zeros leaves every enable as it was.
  a_zero_write_idle:
  assert property (s_write_zero |=> $stable(enable))
    else $error("zero mask write changed an enable");

  // An address that selects no register reads as zero.
  a_unmapped_read_zero:
  assert property (reg_rd && rcim_decode(reg_addr) == RCIM_SEL_NONE |=> reg_rdata == 32'h00000000)
    else $error("unmapped address read nonzero");

  // The upper half of the unmasked status has no function and reads zero.
  a_unmasked_reserved:
  assert property (s_read_unmasked |=> reg_rdata[31:16] == 16'h0000)
    else $error("unmasked reserved bits read nonzero");

  // With every packet enable off, no packet line may rise.
  a_packet_off_quiet:
  assert property (enable[7:0] == 8'h00 |=> rx_packet_irq == 8'h00)
    else $error("packet line high with enables off");

  // With every threshold enable off, no threshold line may rise.
  a_low_off_quiet:
  assert property (enable[15:8] == 8'h00 |=> rx_low_buffer_irq == 8'h00)
    else $error("threshold line high with enables off");

  // With every pulse enable off, no pulse line may rise.
  a_pulse_off_quiet:
  assert property (enable[23:16] == 8'h00 |=> rx_pulse_irq == 8'h00)
    else $error("pulse line high with enables off");

  // With no packet event captured, no packet line may rise.
  a_packet_needs_event:
  assert property (unmasked[7:0] == 8'h00 |=> rx_packet_irq == 8'h00)
    else $error("packet line high without an event");

  // Channel 0 of the packet line follows its source two cycles later, gated by its enable.
  a_packet_chan0:
  assert property (##1 rx_packet_irq[0] == ($past(rx_packet_event[0], 2) & $past(enable[0])))
    else $error("packet channel 0 not in bit 0");

  // Channel 0 of the threshold line follows its source two cycles later, gated by enable bit 8.
  a_low_chan0:
  assert property (##1 rx_low_buffer_irq[0] == ($past(rx_low_buffer_event[0], 2) & $past(enable[8])))
    else $error("threshold channel 0 not in bit 8");

  // With no threshold event captured, no threshold line may rise.
  a_low_needs_event:
  assert property (unmasked[15:8] == 8'h00 |=> rx_low_buffer_irq == 8'h00)
    else $error("threshold line high without an event");

endmodule

// >>> verif/test_rx_channel_interrupt_masking.sv
`timescale 1ns/1ps
`include "rcim_regs.svh"

module test_rx_channel_interrupt_masking
  import rcim_pkg::*;
;
  logic core_clk;
  logic reset_n;
  logic [7:0] reg_addr;
  logic [31:0] reg_wdata;
  logic reg_wr;
  logic reg_rd;
  logic [31:0] reg_rdata;
  rcim_chan_t rx_packet_event;
  rcim_chan_t rx_low_buffer_event;
  rcim_chan_t rx_pulse_event;
  rcim_chan_t rx_packet_irq;
  rcim_chan_t rx_low_buffer_irq;
  rcim_chan_t rx_pulse_irq;
  int fail_count;
  int checks_done;
  // Reference model: enable mask and the event levels last applied.
  rcim_enable_t m_en;
  rcim_chan_t m_pk;
  rcim_chan_t m_lb;
  rcim_chan_t m_pu;

  rcim_top i_dut (
    .core_clk(core_clk),
    .reset_n(reset_n),
    .reg_addr(reg_addr),
    .reg_wdata(reg_wdata),
    .reg_wr(reg_wr),
    .reg_rd(reg_rd),
    .reg_rdata(reg_rdata),
    .rx_packet_event(rx_packet_event),
    .rx_low_buffer_event(rx_low_buffer_event),
    .rx_pulse_event(rx_pulse_event),
    .rx_packet_irq(rx_packet_irq),
    .rx_low_buffer_irq(rx_low_buffer_irq),
    .rx_pulse_irq(rx_pulse_irq)
  );

  // The clock toggles every half period of 12.5 ns.
  initial
  begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end

  // Prints the counts and the verdict, then ends the run.
  task automatic tally_and_finish();
    $display("Comparisons %0d, mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // Compares one register read against the model.
  task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp, input string what);
    checks_done++;
    if (got !== exp)
    begin
      fail_count++;
      $display("MISMATCH at %0t: %s read %h expected %h", $time, what, got, exp);
    end
  endtask

  // Compares one group of interrupt lines against the model.
  task automatic chk_irq(input rcim_chan_t got, input rcim_chan_t exp, input string what);
    checks_done++;
    if (got !== exp)
    begin
      fail_count++;
      $display("MISMATCH at %0t: %s irq %h expected %h", $time, what, got, exp);
    end
  endtask

  // Expected read data for each address, built from the model.
  function automatic logic [31:0] exp_rd(input logic [7:0] a);
    case (a)
      `RCIM_OFS_UNMASKED: return {16'h0000, m_lb, m_pk};
      `RCIM_OFS_MASKED: return {16'h0000, m_lb & m_en[15:8], m_pk & m_en[7:0]};
      `RCIM_OFS_ENABLE_SET, `RCIM_OFS_ENABLE_CLEAR: return {8'h00, m_en};
      default: return 32'h00000000;
    endcase
  endfunction

  // One write cycle; the model applies set or clear semantics.
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge core_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge core_clk);
    reg_wr <= 1'b0;
    if (a == `RCIM_OFS_ENABLE_SET)
      m_en = m_en | v[23:0];
    if (a == `RCIM_OFS_ENABLE_CLEAR)
      m_en = m_en & ~v[23:0];
  endtask

  // One read cycle; read data are taken in the following cycle and compared.
  task automatic rd_chk(input logic [7:0] a, input string what);
    @(posedge core_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    @(negedge core_clk);
    chk_reg(reg_rdata, exp_rd(a), what);
  endtask

  // Applies event levels and lets them reach status and interrupt lines.
  task automatic ev(input rcim_chan_t pk, input rcim_chan_t lb, input rcim_chan_t pu);
    @(posedge core_clk);
    rx_packet_event <= pk;
    rx_low_buffer_event <= lb;
    rx_pulse_event <= pu;
    m_pk = pk;
    m_lb = lb;
    m_pu = pu;
    repeat (3) @(posedge core_clk);
  endtask

  // Reads every register and checks every interrupt group.
  task automatic check_all();
    rd_chk(`RCIM_OFS_UNMASKED, "unmasked");
    rd_chk(`RCIM_OFS_MASKED, "masked");
    rd_chk(`RCIM_OFS_ENABLE_SET, "set");
    rd_chk(`RCIM_OFS_ENABLE_CLEAR, "clear");
    chk_irq(rx_packet_irq, m_pk & m_en[7:0], "packet");
    chk_irq(rx_low_buffer_irq, m_lb & m_en[15:8], "low buffer");
    chk_irq(rx_pulse_irq, m_pu & m_en[23:16], "pulse");
  endtask

  // Cuts a hung run short.
  initial
  begin
    #2000000;
    fail_count++;
    $display("MISMATCH at %0t: run did not finish in time", $time);
    tally_and_finish();
  end

  // Main sequence.
  initial
  begin
    reset_n = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 32'h00000000;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    rx_packet_event = 8'h00;
    rx_low_buffer_event = 8'h00;
    rx_pulse_event = 8'h00;
    fail_count = 0;
    checks_done = 0;
    m_en = 24'h000000;
    m_pk = 8'h00;
    m_lb = 8'h00;
    m_pu = 8'h00;
    void'($urandom(47543));
    repeat (10) @(posedge core_clk);
    reset_n <= 1'b1;
    repeat (3) @(posedge core_clk);
    // All registers and lines are zero after reset.
    check_all();
    // Walk one enable bit at a time through every field, all sources active.
    ev(8'hFF, 8'hFF, 8'hFF);
    for (int i = 0; i < 24; i++)
    begin
      wr(`RCIM_OFS_ENABLE_SET, 32'h00000001 << i);
      check_all();
    end
    for (int i = 0; i < 24; i++)
    begin
      wr(`RCIM_OFS_ENABLE_CLEAR, 32'h00000001 << i);
      check_all();
    end
    // After one set write of 00A5005A, writes to read-only, unmapped and reserved places and a zero clear change nothing.
    wr(`RCIM_OFS_ENABLE_SET, 32'h00A5005A);
    wr(`RCIM_OFS_UNMASKED, 32'hFFFFFFFF);
    wr(`RCIM_OFS_MASKED, 32'hFFFFFFFF);
    wr(8'h10, 32'hFFFFFFFF);
    wr(`RCIM_OFS_ENABLE_SET, 32'hFF000000);
    wr(`RCIM_OFS_ENABLE_CLEAR, 32'hFF000000);
    wr(`RCIM_OFS_ENABLE_CLEAR, 32'h00000000);
    check_all();
    rd_chk(8'h10, "unmapped");
    // Read data stand one cycle only.
    rd_chk(`RCIM_OFS_ENABLE_SET, "set");
    @(negedge core_clk);
    chk_reg(reg_rdata, 32'h00000000, "idle data");
    // Random events, set and clear masks.
    for (int n = 0; n < 40; n++)
    begin
      ev(rcim_chan_t'($urandom), rcim_chan_t'($urandom), rcim_chan_t'($urandom));
      wr(`RCIM_OFS_ENABLE_SET, $urandom);
      check_all();
      wr(`RCIM_OFS_ENABLE_CLEAR, $urandom & $urandom);
      check_all();
    end
    tally_and_finish();
  end
endmodule
